/* hw/baud_gen_pkg.sv */
// constants, types and register map of the serial bit-rate generator
// assumes a single core clock and an axi4-lite register master
`default_nettype none
package baud_gen_pkg;
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;
  localparam logic [7:0] REG_CTRL_OFS      = 8'h00;
  localparam logic [7:0] REG_TMR_OFS       = 8'h04;
  localparam logic [7:0] REG_T1_RELOAD_OFS = 8'h08;
  localparam logic [7:0] REG_T2_RELOAD_OFS = 8'h0c;
  localparam logic [7:0] REG_STATUS_OFS    = 8'h10;
  localparam int unsigned CTRL_MB1_POS  = 0;
  localparam int unsigned CTRL_MB0_POS  = 1;
  localparam int unsigned CTRL_DBL_POS  = 2;
  localparam int unsigned CTRL_TXT2_POS = 3;
  localparam int unsigned CTRL_RXT2_POS = 4;
  localparam int unsigned STAT_T2_POS   = 0;
  localparam int unsigned STAT_T1_POS   = 16;
  localparam int unsigned STAT_MODE_POS = 24;
  localparam int unsigned STAT_T2BR_POS = 26;
  localparam logic [7:0]  TMR_MODE_RST  = 8'h00;
  localparam logic [7:0]  T1_RELOAD_RST = 8'h00;
  localparam logic [15:0] T2_RELOAD_RST = 16'h0000;
  localparam logic [15:0] T2_COUNT_RST  = 16'hffff;
  localparam logic [3:0]  T1_AUTORELOAD_NIB = 4'h2;
  localparam int unsigned MODE0_DIV        = 12;
  localparam int unsigned MODE2_DIV        = 32;
  localparam int unsigned T1_PRESCALE      = 12;
  localparam int unsigned T1_DBL_DIV       = 2;
  localparam int unsigned T2_STEP          = 2;
  localparam int unsigned OVF_PER_BIT      = 16;
  localparam int unsigned T1_RANGE         = 256;
  localparam int unsigned T2_RANGE         = 65536;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    SER_SHIFT  = 2'h0,
    SER_UART8  = 2'h1,
    SER_FIXED9 = 2'h2,
    SER_UART9  = 2'h3
  } serial_mode_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_DATA = 2'h1
  } rd_state_t;

  typedef struct packed {
    logic [7:0] t2ReloadHigh;
    logic [7:0] t2ReloadLow;
    logic [7:0] timer1ReloadHigh;
    logic [7:0] timerModeReg;
    logic       rxTimer2Select;
    logic       txTimer2Select;
    logic       baudDoublerBit;
    logic       serialModeBit0;
    logic       serialModeBit1;
  } baud_cfg_t;
endpackage
`default_nettype wire

/* hw/tick_divider.sv */
// divides a stream of enable pulses by LAST+1
// assumes inc is a per-cycle enable in the core clock domain; held high it counts every clock
`default_nettype none
module tick_divider
  import baud_gen_pkg::*;
#(
  parameter int unsigned      WIDTH = 4,
  parameter logic [WIDTH-1:0] LAST  = '1
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic inc,
  output logic      tick
);
  logic [WIDTH-1:0] cnt_ff;

  // tick is combinational; the caller registers it only for the mode, tx and rx ticks, and uses the timer 1 ones directly
  assign tick = inc && (cnt_ff == LAST);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (tick) begin
      cnt_ff <= '0;
    end else if (inc) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* hw/uart_baud_rate_generator.sv */
// serial bit-rate generator with axi4-lite configuration registers
// assumes the shift logic consumes txTick and rxTick in the core clock domain
//
// What this block does
// R1 - mode 0 shift clock is the core clock divided by 12
// R2 - mode 2 rate is core clock over 64, or over 32 with doubler set
// R3 - modes 1 and 3 time bits from timer 1, timer 2, or one each
// R4 - timer 1 rate is its overflow rate times 2^doubler over 32
// R5 - software keeps the timer 1 interrupt off while it sources bit rates
// R6 - timer 1 overflows count in timer or counter use, any running mode
// R7 - auto-reload timer 1 gives doubler-scaled core/(12*(256-reload))/32
// R8 - timer 2 needs 16 overflows per bit
// R9 - in bit-rate use timer 2 steps once every two core clocks
// R10 - each direction uses timer 2 when its select is set, else timer 1
// R11 - either timer 2 select switches timer 2 into bit-rate generator use
// R12 - transmit and receive may run at different rates together
// R13 - timer 2 rate is core/(32*(65536-reload pair))
// R14 - timer 2 reloads all 16 bits from the reload pair on overflow
// R15 - mode bits 00,01,10,11 select modes 0,1,2,3
// R16 - separate one-cycle transmit and receive ticks go to the shift logic
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`default_nettype none
module uart_baud_rate_generator
  import baud_gen_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  t1OverflowIn,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       txTick,
  output logic                       rxTick
);
  baud_cfg_t         cfg_ff;
  logic              awHeld_ff, wHeld_ff, nxt_awHeld, nxt_wHeld, doWrite;
  logic [7:0]        awAddr_ff;
  logic [31:0]       wData_ff;
  logic [3:0]        wStrb_ff;
  logic              awReady_ff, wReady_ff, bValid_ff, arReady_ff, rValid_ff;
  logic [1:0]        bResp_ff, rResp_ff;
  logic [31:0]       rData_ff;
  rd_state_t         rdState_ff;
  serial_mode_t      modeDec;
  logic              t2BaudMode, halfPhase_ff, t1AutoReload;
  logic              mcTick, t1IntOvf, t1Ovf, t1Half, t1Scaled;
  logic [7:0]        t1Cnt_ff;
  logic [15:0]       t2Cnt_ff, t2Reload;
  logic              t2Ovf;
  logic              mode0Pulse, mode2Pulse, txUartPulse, rxUartPulse;
  logic              txTick_ff, rxTick_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data accepted in either order

  assign doWrite    = awHeld_ff && wHeld_ff && !bValid_ff;
  assign nxt_awHeld = (awHeld_ff && !doWrite) || (s_axi_awvalid && awReady_ff);
  assign nxt_wHeld  = (wHeld_ff && !doWrite) || (s_axi_wvalid && wReady_ff);

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] val,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = val[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic regMapped(input logic [7:0] a);
    return (a == REG_CTRL_OFS) || (a == REG_TMR_OFS) || (a == REG_T1_RELOAD_OFS) ||
           (a == REG_T2_RELOAD_OFS) || (a == REG_STATUS_OFS);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      awHeld_ff  <= 1'b0;
      wHeld_ff   <= 1'b0;
      awReady_ff <= 1'b0;
      wReady_ff  <= 1'b0;
      awAddr_ff  <= 8'h00;
      wData_ff   <= 32'h0000_0000;
      wStrb_ff   <= 4'h0;
    end else begin
      awHeld_ff  <= nxt_awHeld;
      wHeld_ff   <= nxt_wHeld;
      awReady_ff <= !nxt_awHeld;
      wReady_ff  <= !nxt_wHeld;
      if (s_axi_awvalid && awReady_ff) begin
        awAddr_ff <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && wReady_ff) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bValid_ff <= 1'b0;
      bResp_ff  <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_ff <= 1'b1;
      bResp_ff  <= regMapped(awAddr_ff) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bValid_ff <= 1'b0;
    end
  end

  // status is read-only; writes to it are accepted and dropped
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_ff <= '{t2ReloadHigh: T2_RELOAD_RST[15:8], t2ReloadLow: T2_RELOAD_RST[7:0],
                  timer1ReloadHigh: T1_RELOAD_RST, timerModeReg: TMR_MODE_RST, default: 1'b0};
    end else if (doWrite) begin
      case (awAddr_ff)
        REG_CTRL_OFS: begin
          if (wStrb_ff[0]) begin
            cfg_ff.serialModeBit1 <= wData_ff[CTRL_MB1_POS];
            cfg_ff.serialModeBit0 <= wData_ff[CTRL_MB0_POS];
            cfg_ff.baudDoublerBit <= wData_ff[CTRL_DBL_POS];
            cfg_ff.txTimer2Select <= wData_ff[CTRL_TXT2_POS];
            cfg_ff.rxTimer2Select <= wData_ff[CTRL_RXT2_POS];
          end
        end
        REG_TMR_OFS: begin
          if (wStrb_ff[0]) begin
            cfg_ff.timerModeReg <= wData_ff[7:0];
          end
        end
        REG_T1_RELOAD_OFS: begin
          if (wStrb_ff[0]) begin
            cfg_ff.timer1ReloadHigh <= wData_ff[7:0];
          end
        end
        REG_T2_RELOAD_OFS: begin
          {cfg_ff.t2ReloadHigh, cfg_ff.t2ReloadLow} <=
            16'(mergeStrb({16'h0000, t2Reload}, wData_ff, wStrb_ff));
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  function automatic logic [31:0] readMux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      REG_CTRL_OFS: begin
        v[CTRL_MB1_POS]  = cfg_ff.serialModeBit1;
        v[CTRL_MB0_POS]  = cfg_ff.serialModeBit0;
        v[CTRL_DBL_POS]  = cfg_ff.baudDoublerBit;
        v[CTRL_TXT2_POS] = cfg_ff.txTimer2Select;
        v[CTRL_RXT2_POS] = cfg_ff.rxTimer2Select;
      end
      REG_TMR_OFS:       v[7:0]  = cfg_ff.timerModeReg;
      REG_T1_RELOAD_OFS: v[7:0]  = cfg_ff.timer1ReloadHigh;
      REG_T2_RELOAD_OFS: v[15:0] = t2Reload;
      REG_STATUS_OFS: begin
        v[STAT_T2_POS +: 16]  = t2Cnt_ff;
        v[STAT_T1_POS +: 8]   = t1Cnt_ff;
        v[STAT_MODE_POS +: 2] = modeDec;
        v[STAT_T2BR_POS]      = t2BaudMode;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdState_ff <= RD_IDLE;
      arReady_ff <= 1'b0;
      rValid_ff  <= 1'b0;
      rData_ff   <= 32'h0000_0000;
      rResp_ff   <= RESP_OKAY;
    end else begin
      case (rdState_ff)
        RD_IDLE: begin
          arReady_ff <= 1'b1;
          if (s_axi_arvalid && arReady_ff) begin
            arReady_ff <= 1'b0;
            rValid_ff  <= 1'b1;
            rData_ff   <= readMux({s_axi_araddr[7:2], 2'h0});
            rResp_ff   <= regMapped({s_axi_araddr[7:2], 2'h0}) ? RESP_OKAY : RESP_DECERR;
            rdState_ff <= RD_DATA;
          end
        end
        RD_DATA: begin
          if (s_axi_rready) begin
            rValid_ff  <= 1'b0;
            arReady_ff <= 1'b1;
            rdState_ff <= RD_IDLE;
          end
        end
        default: begin
          rValid_ff  <= 1'b0;
          arReady_ff <= 1'b0;
          rdState_ff <= RD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode and shared prescalers

  assign modeDec      = serial_mode_t'({cfg_ff.serialModeBit0, cfg_ff.serialModeBit1}); // R15
  assign t2BaudMode   = cfg_ff.txTimer2Select || cfg_ff.rxTimer2Select; // R11
  assign t2Reload     = {cfg_ff.t2ReloadHigh, cfg_ff.t2ReloadLow};
  assign t1AutoReload = (cfg_ff.timerModeReg[7:4] == T1_AUTORELOAD_NIB);

  // one pulse every other core clock: timer 2 step and undoubled mode 2 base
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      halfPhase_ff <= 1'b0;
    end else begin
      halfPhase_ff <= !halfPhase_ff;
    end
  end

  tick_divider #(.WIDTH(4), .LAST(4'(MODE0_DIV - 1))) mode0Div (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .inc     (1'b1),
    .tick    (mode0Pulse)
  ); // R1

  tick_divider #(.WIDTH(5), .LAST(5'(MODE2_DIV - 1))) mode2Div (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .inc     (cfg_ff.baudDoublerBit || halfPhase_ff),
    .tick    (mode2Pulse)
  ); // R2

  ////////////////////////////////////////////////////////////////////////////////
  // timer 1: built-in auto-reload timer, otherwise overflows of the external timer

  tick_divider #(.WIDTH(4), .LAST(4'(T1_PRESCALE - 1))) t1Prescale (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .inc     (1'b1),
    .tick    (mcTick)
  );

  assign t1IntOvf = t1AutoReload && mcTick && (t1Cnt_ff == 8'hff);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      t1Cnt_ff <= 8'h00;
    end else if (t1IntOvf) begin
      t1Cnt_ff <= cfg_ff.timer1ReloadHigh; // R7
    end else if (t1AutoReload && mcTick) begin
      t1Cnt_ff <= t1Cnt_ff + 8'h01;
    end
  end

  // counter use and the other running modes come in as overflow pulses
  assign t1Ovf = t1AutoReload ? t1IntOvf : t1OverflowIn; // R6

  tick_divider #(.WIDTH(1), .LAST(1'(T1_DBL_DIV - 1))) t1DblDiv (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .inc     (t1Ovf),
    .tick    (t1Half)
  );

  assign t1Scaled = cfg_ff.baudDoublerBit ? t1Ovf : t1Half; // R4

  ////////////////////////////////////////////////////////////////////////////////
  // timer 2 in bit-rate generator use; held while neither select is set

  assign t2Ovf = t2BaudMode && halfPhase_ff && (t2Cnt_ff == 16'hffff); // R13

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      t2Cnt_ff <= T2_COUNT_RST; // top of range: first step loads the reload pair
    end else if (t2Ovf) begin
      t2Cnt_ff <= t2Reload; // R14
    end else if (t2BaudMode && halfPhase_ff) begin
      t2Cnt_ff <= t2Cnt_ff + 16'h0001; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-direction source and divide by 16 (R3 R12)

  tick_divider #(.WIDTH(4), .LAST(4'(OVF_PER_BIT - 1))) txDiv (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .inc     (cfg_ff.txTimer2Select ? t2Ovf : t1Scaled),
    .tick    (txUartPulse)
  ); // R8 R10 R12

  tick_divider #(.WIDTH(4), .LAST(4'(OVF_PER_BIT - 1))) rxDiv (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .inc     (cfg_ff.rxTimer2Select ? t2Ovf : t1Scaled),
    .tick    (rxUartPulse)
  ); // R8 R10

  // registered so both ticks are clean one-cycle pulses
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txTick_ff <= 1'b0;
      rxTick_ff <= 1'b0;
    end else begin
      case (modeDec)
        SER_SHIFT: begin
          txTick_ff <= mode0Pulse; // R1 R16
          rxTick_ff <= mode0Pulse;
        end
        SER_FIXED9: begin
          txTick_ff <= mode2Pulse; // R2 R16
          rxTick_ff <= mode2Pulse;
        end
        default: begin
          txTick_ff <= txUartPulse; // R3 R16
          rxTick_ff <= rxUartPulse;
        end
      endcase
    end
  end

  assign s_axi_awready = awReady_ff;
  assign s_axi_wready  = wReady_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rdata   = rData_ff;
  assign s_axi_rresp   = rResp_ff;
  assign txTick        = txTick_ff;
  assign rxTick        = rxTick_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks: gap between ticks once two ticks have passed since the last write

  logic [31:0] txGap_ff, rxGap_ff, t1Period, t2Period;
  logic [1:0]  txSeen_ff, rxSeen_ff;

  assign t1Period = 32'(T1_PRESCALE) * (32'(T1_RANGE) - {24'h0, cfg_ff.timer1ReloadHigh});
  assign t2Period = 32'(T2_STEP) * (32'(T2_RANGE) - {16'h0, t2Reload});

  always_ff @(posedge clk_sys) begin
    if (sys_rst || doWrite) begin
      txSeen_ff <= 2'h0;
      rxSeen_ff <= 2'h0;
    end else begin
      if (txTick_ff && txSeen_ff != 2'h2) txSeen_ff <= txSeen_ff + 2'h1;
      if (rxTick_ff && rxSeen_ff != 2'h2) rxSeen_ff <= rxSeen_ff + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txGap_ff <= 32'h0000_0001;
      rxGap_ff <= 32'h0000_0001;
    end else begin
      txGap_ff <= txTick_ff ? 32'h0000_0001 : txGap_ff + 32'h0000_0001;
      rxGap_ff <= rxTick_ff ? 32'h0000_0001 : rxGap_ff + 32'h0000_0001;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence t2StepSeq;
    t2BaudMode && halfPhase_ff && !t2Ovf && !doWrite;
  endsequence

  mode0_rate_a: assert property (txTick_ff && txSeen_ff == 2'h2 && modeDec == SER_SHIFT |-> txGap_ff == 32'd12) // R1
    else $error("mode 0 tick spacing is not 12 clocks");
  mode2_rate_a: assert property (txTick_ff && txSeen_ff == 2'h2 && modeDec == SER_FIXED9 |->
      txGap_ff == (cfg_ff.baudDoublerBit ? 32'd32 : 32'd64)) // R2
    else $error("mode 2 tick spacing wrong");
  t1_rate_a: assert property (txTick_ff && txSeen_ff == 2'h2 && modeDec[0] && !cfg_ff.txTimer2Select && t1AutoReload
      |-> txGap_ff == t1Period * (cfg_ff.baudDoublerBit ? 32'd16 : 32'd32)) // R4
    else $error("timer 1 bit spacing wrong");
  t2_tx_rate_a: assert property (txTick_ff && txSeen_ff == 2'h2 && modeDec[0] && cfg_ff.txTimer2Select
      |-> txGap_ff == 32'd16 * t2Period) // R13
    else $error("timer 2 transmit spacing wrong");
  t2_rx_rate_a: assert property (rxTick_ff && rxSeen_ff == 2'h2 && modeDec[0] && cfg_ff.rxTimer2Select
      |-> rxGap_ff == 32'd16 * t2Period) // R10
    else $error("timer 2 receive spacing wrong");
  t2_reload_a: assert property (t2Ovf && !doWrite |=> t2Cnt_ff == $past(t2Reload)) // R14
    else $error("timer 2 did not reload");
  t2_step_a: assert property (t2StepSeq |=> t2Cnt_ff == $past(t2Cnt_ff) + 16'h0001 ##1 $stable(t2Cnt_ff)) // R9
    else $error("timer 2 step not every two clocks");
  t2_hold_a: assert property (!t2BaudMode && !$past(t2BaudMode) |-> $stable(t2Cnt_ff)) // R11
    else $error("timer 2 moved outside bit-rate use");
  tick_width_a: assert property (txTick_ff || rxTick_ff |=> (!txTick_ff || $past(!txTick_ff))
      && (!rxTick_ff || $past(!rxTick_ff))) // R16
    else $error("tick longer than one cycle");
endmodule
`default_nettype wire

/* tb/shift_logic_model.sv */
// model of the serial shift logic: measures the bit time between rate ticks
// assumes txTick and rxTick come from the clk_sys domain
`default_nettype none
module shift_logic_model (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        txTick,
  input  wire logic        rxTick,
  output logic [31:0]      txGap_ff,
  output logic [31:0]      rxGap_ff,
  output logic [31:0]      txSeen_ff,
  output logic [31:0]      rxSeen_ff,
  output logic [31:0]      wide_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] txCnt_ff;
  logic [31:0] rxCnt_ff;
  logic        txPrev_ff;
  logic        rxPrev_ff;
  ////////////////////////////////////////////////////////////////////////////
  // one bit moves per tick, so the gap is the bit time seen by the shifter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txCnt_ff  <= 32'h0;
      txGap_ff  <= 32'h0;
      txSeen_ff <= 32'h0;
    end else if (txTick) begin
      txCnt_ff  <= 32'h1;
      txGap_ff  <= txCnt_ff;
      txSeen_ff <= txSeen_ff + 32'h1;
    end else begin
      txCnt_ff <= txCnt_ff + 32'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rxCnt_ff  <= 32'h0;
      rxGap_ff  <= 32'h0;
      rxSeen_ff <= 32'h0;
    end else if (rxTick) begin
      rxCnt_ff  <= 32'h1;
      rxGap_ff  <= rxCnt_ff;
      rxSeen_ff <= rxSeen_ff + 32'h1;
    end else begin
      rxCnt_ff <= rxCnt_ff + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // a tick held two cycles would shift two bits, so count those
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txPrev_ff <= 1'b0;
      rxPrev_ff <= 1'b0;
      wide_ff   <= 32'h0;
    end else begin
      txPrev_ff <= txTick;
      rxPrev_ff <= rxTick;
      if ((txTick && txPrev_ff) || (rxTick && rxPrev_ff)) begin
        wide_ff <= wide_ff + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/uart_baud_rate_generator_tb.sv */
// self-checking bench: sets the generator up over axi4-lite, measures tick gaps
// assumes baud_gen_pkg and the shift logic model are compiled first
`default_nettype none
module uart_baud_rate_generator_tb
  import baud_gen_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk_sys;
  logic                  sys_rst;
  logic                  t1OverflowIn = 1'b0;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr;
  logic                  s_axi_awvalid;
  logic                  s_axi_awready;
  logic [AXI_DATA_W-1:0] s_axi_wdata;
  logic [3:0]            s_axi_wstrb;
  logic                  s_axi_wvalid;
  logic                  s_axi_wready;
  logic [1:0]            s_axi_bresp;
  logic                  s_axi_bvalid;
  logic                  s_axi_bready;
  logic [AXI_ADDR_W-1:0] s_axi_araddr;
  logic                  s_axi_arvalid;
  logic                  s_axi_arready;
  logic [AXI_DATA_W-1:0] s_axi_rdata;
  logic [1:0]            s_axi_rresp;
  logic                  s_axi_rvalid;
  logic                  s_axi_rready;
  logic                  txTick;
  logic                  rxTick;
  logic [31:0]           txGap_ff;
  logic [31:0]           rxGap_ff;
  logic [31:0]           txSeen_ff;
  logic [31:0]           rxSeen_ff;
  logic [31:0]           wide_ff;
  logic [1:0]            ovfDiv_ff = 2'h0;
  int                    mismatches;
  int                    nCompared;
  ////////////////////////////////////////////////////////////////////////////
  uart_baud_rate_generator dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .t1OverflowIn(t1OverflowIn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txTick(txTick), .rxTick(rxTick));
  shift_logic_model shifter (.clk_sys(clk_sys), .sys_rst(sys_rst), .txTick(txTick), .rxTick(rxTick),
    .txGap_ff(txGap_ff), .rxGap_ff(rxGap_ff), .txSeen_ff(txSeen_ff), .rxSeen_ff(rxSeen_ff),
    .wide_ff(wide_ff));
  ////////////////////////////////////////////////////////////////////////////
  always #50 clk_sys = ~clk_sys;
  // external timer 1 overflows every 4 clocks; ignored while auto-reload is chosen
  always @(posedge clk_sys) begin
    ovfDiv_ff    <= ovfDiv_ff + 2'h1;
    t1OverflowIn <= (ovfDiv_ff == 2'h3);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic give_up;
    mismatches++;
    $display("ERROR at %0t ns: wait ran out", $time);
    end_of_test();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk_sys);
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) give_up();
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  // the mask keeps free-running counters in the status word out of the compare
  task automatic read_check(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
                            input logic [1:0] er);
    int n;
    @(posedge clk_sys);
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50) give_up();
    check(s_axi_rdata & mask, exp);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // first gaps after a change keep the old divider phase, so judge the third
  task automatic wait_ticks(input int n);
    logic [31:0] tx0;
    logic [31:0] rx0;
    int          k;
    tx0 = txSeen_ff;
    rx0 = rxSeen_ff;
    k = 0;
    while ((txSeen_ff < tx0 + n || rxSeen_ff < rx0 + n) && k < 40000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 40000) give_up();
  endtask
  // the block has no timer 1 interrupt, so nothing here can enable one
  task automatic run_case(input logic [7:0] ctrl, input logic [7:0] timer_mode_reg, input logic [7:0] t1,
                          input logic [15:0] t2, input logic [31:0] expTx, input logic [31:0] expRx);
    axi_write(REG_TMR_OFS, {24'h0, timer_mode_reg}, RESP_OKAY);
    axi_write(REG_T1_RELOAD_OFS, {24'h0, t1}, RESP_OKAY);
    axi_write(REG_T2_RELOAD_OFS, {16'h0, t2}, RESP_OKAY);
    axi_write(REG_CTRL_OFS, {24'h0, ctrl}, RESP_OKAY);
    wait_ticks(3);
    check(txGap_ff, expTx);
    check(rxGap_ff, expRx);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    mismatches = 0;
    nCompared = 0;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    read_check(REG_CTRL_OFS, 32'hffffffff, 32'h0, RESP_OKAY);
    read_check(REG_TMR_OFS, 32'hffffffff, {24'h0, TMR_MODE_RST}, RESP_OKAY);
    read_check(REG_T1_RELOAD_OFS, 32'hffffffff, {24'h0, T1_RELOAD_RST}, RESP_OKAY);
    read_check(REG_T2_RELOAD_OFS, 32'hffffffff, {16'h0, T2_RELOAD_RST}, RESP_OKAY);
    read_check(8'h14, 32'hffffffff, 32'h0, RESP_DECERR);
    axi_write(8'h14, 32'h0000001f, RESP_DECERR);
    run_case(8'h00, 8'h20, 8'hff, 16'hfffe, 32'h0000000c, 32'h0000000c);
    read_check(REG_STATUS_OFS, 32'h07000000, 32'h0, RESP_OKAY);
    run_case(8'h02, 8'h20, 8'hff, 16'hfffe, 32'h00000040, 32'h00000040);
    run_case(8'h06, 8'h20, 8'hff, 16'hfffe, 32'h00000020, 32'h00000020);
    run_case(8'h01, 8'h20, 8'hff, 16'hfffe, 32'h00000180, 32'h00000180);
    run_case(8'h07, 8'h20, 8'hfd, 16'hfffe, 32'h00000240, 32'h00000240);
    run_case(8'h05, 8'h00, 8'hfd, 16'hfffe, 32'h00000040, 32'h00000040);
    run_case(8'h01, 8'h50, 8'hfd, 16'hfffe, 32'h00000080, 32'h00000080);
    run_case(8'h0d, 8'h20, 8'hff, 16'hfffe, 32'h00000040, 32'h000000c0);
    read_check(REG_STATUS_OFS, 32'h07000000, 32'h05000000, RESP_OKAY);
    run_case(8'h13, 8'h20, 8'hff, 16'hfffd, 32'h00000180, 32'h00000060);
    read_check(REG_T2_RELOAD_OFS, 32'hffffffff, 32'h0000fffd, RESP_OKAY);
    axi_write(REG_STATUS_OFS, 32'hffffffff, RESP_OKAY);
    read_check(REG_STATUS_OFS, 32'h07000000, 32'h07000000, RESP_OKAY);
    run_case(8'h1b, 8'h20, 8'hff, 16'hff00, 32'h00002000, 32'h00002000);
    check(wide_ff, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
